// file: design/pfc_regs.svh
// Register map, field positions and timing counts of the pause flow control block.
// Assumes a 20 MHz APB clock; included by bare name from the design files.
`ifndef PFC_REGS_SVH
`define PFC_REGS_SVH

// Register offset (byte address) and address width
`define PFC_ADDR_W              12
`define PFC_PAUSE_FLOW_CONTROL  12'h044
`define PFC_PAUSE_FLOW_RESET    32'h00000000

// Field positions of pause_flow_control
`define PFC_MANUAL_PAUSE_ENABLE 31
`define PFC_PAUSE_ON_MCAST      30
`define PFC_PAUSE_ON_STATION    29
`define PFC_PAUSE_TIMING_ACTIVE 23
`define PFC_PAUSE_FRAME_SEEN    22
`define PFC_PAUSE_AUTONEG       21
`define PFC_MANUAL_COUNT_LOAD   16
`define PFC_COUNT_MSB           15
`define PFC_COUNT_W             16

// Reserved multicast destination of pause frames
`define PFC_RESERVED_MCAST      48'h0180C2000001

// Slot time and its length in clock cycles, rounded up
`define PFC_CLK_PERIOD_NS       50
`define PFC_SLOT_BITS           512
`define PFC_BIT_NS_100M         10
`define PFC_BIT_NS_10M          100
`define PFC_SLOT_NS_100M        (`PFC_SLOT_BITS * `PFC_BIT_NS_100M)
`define PFC_SLOT_NS_10M         (`PFC_SLOT_BITS * `PFC_BIT_NS_10M)
`define PFC_SLOT_CYC_100M       ((`PFC_SLOT_NS_100M + `PFC_CLK_PERIOD_NS - 1) / `PFC_CLK_PERIOD_NS)
`define PFC_SLOT_CYC_10M        ((`PFC_SLOT_NS_10M + `PFC_CLK_PERIOD_NS - 1) / `PFC_CLK_PERIOD_NS)
`define PFC_SLOT_CNT_W          11

`endif

// file: design/pfc_pkg.sv
// Types shared by the pause flow control modules.
// Assumes nothing beyond a SystemVerilog compiler.
package pfc_pkg;

  // Pause interval state, one-hot
  typedef enum logic [1:0] {
    PFC_IDLE   = 2'b01,
    PFC_TIMING = 2'b10
  } pfc_state_t;

endpackage : pfc_pkg

// file: design/pfc_slot_if.sv
// Carrier between the pause controller and its slot timer.
// Assumes both ends run on the same pclk.
`timescale 1ns/1ps
interface pfc_slot_if;
  logic run;        // Timer counts while high
  logic restart;    // Start a fresh slot
  logic speed_100;  // 100 Mb/s when high, else 10 Mb/s
  logic tick;       // One-cycle pulse at each slot end

  modport ctrl  (output run, output restart, output speed_100, input tick);
  modport timer (input run, input restart, input speed_100, output tick);
endinterface : pfc_slot_if

// file: design/pfc_slot_timer.sv
// Slot time generator: one tick every 512 bit times at the link speed.
// Assumes pclk at 20 MHz and a clock enable that freezes it.
`timescale 1ns/1ps
`include "pfc_regs.svh"
module pfc_slot_timer (
  // Clock and reset
  input  wire logic  pclk,
  input  wire logic  presetn,
  input  wire logic  clk_en,
  // Controller side
  pfc_slot_if.timer  slot
);
  import pfc_pkg::*;

  localparam logic [`PFC_SLOT_CNT_W-1:0] SLOT_100 = `PFC_SLOT_CNT_W'(`PFC_SLOT_CYC_100M - 1);
  localparam logic [`PFC_SLOT_CNT_W-1:0] SLOT_10  = `PFC_SLOT_CNT_W'(`PFC_SLOT_CYC_10M - 1);

  logic [`PFC_SLOT_CNT_W-1:0] cyc_q, cyc_d;
  logic                       tick_q, tick_d;
  logic [`PFC_SLOT_CNT_W-1:0] last;

  // Next cycle count and tick
  always_comb begin
    last   = slot.speed_100 ? SLOT_100 : SLOT_10;
    cyc_d  = cyc_q;
    tick_d = 1'b0;
    if (slot.restart || !slot.run) begin
      cyc_d = '0;
    end else if (cyc_q >= last) begin
      cyc_d  = '0;
      tick_d = 1'b1; // [R14]
    end else begin
      cyc_d = cyc_q + 1'b1;
    end
  end

  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_q  <= '0;
      tick_q <= 1'b0;
    end else if (clk_en) begin
      cyc_q  <= cyc_d;
      tick_q <= tick_d;
    end
  end

  assign slot.tick = tick_q && clk_en;

  // Slot count never runs past the 10 Mb/s slot
  chk_slot_bound: assert property (@(posedge pclk) disable iff (!presetn) cyc_q <= SLOT_10) // [R14]
    else $error("slot counter out of range");

endmodule : pfc_slot_timer

// file: design/pfc_top.sv
// Pause frame flow control: pause frame qualification, transmit pause timer, APB register.
// Assumes APB master on pclk, receive filter results delivered as one-cycle strobes.
`timescale 1ns/1ps
`include "pfc_regs.svh"

// Functional notes
// (R1) Pause reception is enabled by the manual enable bit OR the negotiated pause bit.
// (R2) Clearing the manual enable, when it alone enabled reception, ends any running pause at once.
// (R3) With the multicast option set, frames to 01-80-C2-00-00-01 exactly are accepted.
// (R4) Multicast acceptance needs no other address filter mode, hashing included.
// (R5) With the station option set, frames hitting the perfect match or a pattern buffer are accepted.
// (R6) An accepted frame loads its pause length and holds transmit off for that many slot times.
// (R7) The read-only active bit reads one exactly while a pause interval is being timed.
// (R8) The read-only received bit is set on a pause frame and stays set until that interval ends.
// (R9) The negotiated bit is set only when autonegotiation agreed pause and pause was advertised.
// (R10) Writing one to the manual load bit copies bits 15-0 into the counter and starts an interval.
// (R11) The manual load bit is write-only and self-clearing and always reads zero.
// (R12) Bits 15-0 read back the live pause counter.
// (R13) A manual load acts only when received and active are both zero, else it is ignored.
// (R14) While active the counter drops once per 512-bit slot, and at zero the pause ends.
// (R15) A further accepted frame during a pause reloads the counter with the new length.
module pfc_top (
  // Clock, reset, enable
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     clk_en,
  // APB slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [`PFC_ADDR_W-1:0]   paddr,
  input  wire logic [31:0]              pwdata,
  output logic                          pready,
  output logic [31:0]                   prdata,
  output logic                          pslverr,
  // Receive side pause frame report
  input  wire logic                     rx_pause_valid,
  input  wire logic [47:0]              rx_dest_addr,
  input  wire logic [15:0]              rx_pause_length,
  input  wire logic                     rx_perfect_hit,
  input  wire logic                     rx_pattern_hit,
  // Link status
  input  wire logic                     link_speed_100,
  input  wire logic                     an_pause_agreed,
  input  wire logic                     cfg_pause_advertise,
  // Transmit MAC hold-off
  output logic                          tx_pause_hold
);
  import pfc_pkg::*;

  // Longest legal wait between two counter moves: one 10 Mb/s slot plus margin
  localparam int CHK_SLOT_MAX = `PFC_SLOT_CYC_10M + 6;

  pfc_slot_if slot ();

  pfc_slot_timer i_pfc_slot_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .slot    (slot)
  );

  // Control and status state
  logic                     manual_pause_enable_q, manual_pause_enable_d;
  logic                     pause_on_reserved_multicast_q, pause_on_reserved_multicast_d;
  logic                     pause_on_station_match_q, pause_on_station_match_d;
  logic                     pause_frame_seen_q, pause_frame_seen_d;
  logic                     pause_autoneg_agreed_q, pause_autoneg_agreed_d;
  logic [15:0]              pause_counter_value_q, pause_counter_value_d;
  pfc_state_t               state_q, state_d;
  logic                     hold_q, hold_d;
  // Bus answer state
  logic                     pready_q, pready_d;
  logic [31:0]              prdata_q, prdata_d;
  logic                     pslverr_q, pslverr_d;

  // Decoded events
  logic                     hit_reg;
  logic                     wr_commit;
  logic                     rx_enable;
  logic                     mcast_hit;
  logic                     station_hit;
  logic                     frame_accept;
  logic                     manual_load;
  logic                     terminate;
  logic                     pause_timing_active;

  // Bus decode: a write commits at the edge where pready is seen high
  always_comb begin
    hit_reg   = (paddr == `PFC_PAUSE_FLOW_CONTROL);
    wr_commit = psel && penable && pready_q && pwrite && hit_reg;
  end

  // Frame qualification and pause control events
  always_comb begin
    pause_timing_active = (state_q == PFC_TIMING);
    rx_enable   = manual_pause_enable_q || pause_autoneg_agreed_q; // [R1]
    mcast_hit   = pause_on_reserved_multicast_q && (rx_dest_addr == `PFC_RESERVED_MCAST); // [R3] [R4]
    station_hit = pause_on_station_match_q && (rx_perfect_hit || rx_pattern_hit); // [R5]
    frame_accept = rx_pause_valid && rx_enable && (mcast_hit || station_hit);
    terminate   = wr_commit && manual_pause_enable_q && !pwdata[`PFC_MANUAL_PAUSE_ENABLE]
                  && !pause_autoneg_agreed_q; // [R2]
    manual_load = wr_commit && pwdata[`PFC_MANUAL_COUNT_LOAD]
                  && !pause_frame_seen_q && !pause_timing_active; // [R10] [R13]
  end

  // Slot timer control: restart on each new interval so the first slot is whole
  assign slot.run       = pause_timing_active;
  assign slot.restart   = frame_accept || manual_load || terminate;
  assign slot.speed_100 = link_speed_100;

  // Next values of the control fields
  always_comb begin
    manual_pause_enable_d         = manual_pause_enable_q;
    pause_on_reserved_multicast_d = pause_on_reserved_multicast_q;
    pause_on_station_match_d      = pause_on_station_match_q;
    pause_autoneg_agreed_d        = an_pause_agreed && cfg_pause_advertise; // [R9]
    if (wr_commit) begin
      manual_pause_enable_d         = pwdata[`PFC_MANUAL_PAUSE_ENABLE];
      pause_on_reserved_multicast_d = pwdata[`PFC_PAUSE_ON_MCAST];
      pause_on_station_match_d      = pwdata[`PFC_PAUSE_ON_STATION];
    end
  end

  // Next values of the pause interval state
  always_comb begin
    state_d               = state_q;
    pause_counter_value_d = pause_counter_value_q;
    pause_frame_seen_d    = pause_frame_seen_q;
    unique case (state_q)
      PFC_IDLE: begin
        if (frame_accept) begin
          pause_counter_value_d = rx_pause_length; // [R6]
          pause_frame_seen_d    = (rx_pause_length != 16'h0000); // [R8]
          state_d               = (rx_pause_length != 16'h0000) ? PFC_TIMING : PFC_IDLE;
        end else if (manual_load) begin
          pause_counter_value_d = pwdata[`PFC_COUNT_MSB:0]; // [R10]
          state_d               = (pwdata[`PFC_COUNT_MSB:0] != 16'h0000) ? PFC_TIMING : PFC_IDLE;
        end
      end
      PFC_TIMING: begin
        if (terminate) begin
          pause_counter_value_d = 16'h0000; // [R2]
          pause_frame_seen_d    = 1'b0;
          state_d               = PFC_IDLE;
        end else if (frame_accept) begin
          pause_counter_value_d = rx_pause_length; // [R15]
          pause_frame_seen_d    = (rx_pause_length != 16'h0000);
          state_d               = (rx_pause_length != 16'h0000) ? PFC_TIMING : PFC_IDLE;
        end else if (slot.tick) begin
          pause_counter_value_d = pause_counter_value_q - 16'h0001; // [R14]
          if (pause_counter_value_q == 16'h0001) begin
            pause_frame_seen_d = 1'b0; // [R8]
            state_d            = PFC_IDLE;
          end
        end
      end
      default: begin
        state_d               = PFC_IDLE;
        pause_counter_value_d = 16'h0000;
        pause_frame_seen_d    = 1'b0;
      end
    endcase
    hold_d = (state_d == PFC_TIMING); // [R6]
  end

  // Next values of the bus answer; the answer comes one cycle into the access phase
  always_comb begin
    pready_d  = 1'b0;
    prdata_d  = prdata_q;
    pslverr_d = 1'b0;
    if (psel && penable && !pready_q) begin
      pready_d  = 1'b1;
      pslverr_d = !hit_reg;
      prdata_d  = 32'h00000000;
      if (!pwrite && hit_reg) begin
        prdata_d[`PFC_MANUAL_PAUSE_ENABLE] = manual_pause_enable_q;
        prdata_d[`PFC_PAUSE_ON_MCAST]      = pause_on_reserved_multicast_q;
        prdata_d[`PFC_PAUSE_ON_STATION]    = pause_on_station_match_q;
        prdata_d[`PFC_PAUSE_TIMING_ACTIVE] = pause_timing_active; // [R7]
        prdata_d[`PFC_PAUSE_FRAME_SEEN]    = pause_frame_seen_q; // [R8]
        prdata_d[`PFC_PAUSE_AUTONEG]       = pause_autoneg_agreed_q; // [R9]
        prdata_d[`PFC_MANUAL_COUNT_LOAD]   = 1'b0; // [R11]
        prdata_d[`PFC_COUNT_MSB:0]         = pause_counter_value_q; // [R12]
      end
    end
  end

  // Registers, frozen while the clock enable is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      manual_pause_enable_q         <= 1'b0;
      pause_on_reserved_multicast_q <= 1'b0;
      pause_on_station_match_q      <= 1'b0;
      pause_autoneg_agreed_q        <= 1'b0;
      pause_frame_seen_q            <= 1'b0;
      pause_counter_value_q         <= 16'h0000;
      state_q                       <= PFC_IDLE;
      hold_q                        <= 1'b0;
      pready_q                      <= 1'b0;
      prdata_q                      <= `PFC_PAUSE_FLOW_RESET;
      pslverr_q                     <= 1'b0;
    end else if (clk_en) begin
      manual_pause_enable_q         <= manual_pause_enable_d;
      pause_on_reserved_multicast_q <= pause_on_reserved_multicast_d;
      pause_on_station_match_q      <= pause_on_station_match_d;
      pause_autoneg_agreed_q        <= pause_autoneg_agreed_d;
      pause_frame_seen_q            <= pause_frame_seen_d;
      pause_counter_value_q         <= pause_counter_value_d;
      state_q                       <= state_d;
      hold_q                        <= hold_d;
      pready_q                      <= pready_d;
      prdata_q                      <= prdata_d;
      pslverr_q                     <= pslverr_d;
    end
  end

  // Outputs straight from flip-flops
  assign pready        = pready_q;
  assign prdata        = prdata_q;
  assign pslverr       = pslverr_q;
  assign tx_pause_hold = hold_q;

  // Checker helper: cycles since the pause counter last moved while a pause runs
  logic [`PFC_SLOT_CNT_W-1:0] stall_q, stall_d;

  // Next stall count; cleared when idle, on a timer restart or when the counter moves
  always_comb begin
    stall_d = stall_q;
    if (!pause_timing_active || slot.restart || (pause_counter_value_d != pause_counter_value_q)) begin
      stall_d = '0;
    end else if (stall_q != {`PFC_SLOT_CNT_W{1'b1}}) begin
      stall_d = stall_q + 1'b1; // Saturates so the check cannot wrap
    end
  end

  // Stall count register, frozen with the rest of the state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stall_q <= '0;
    end else if (clk_en) begin
      stall_q <= stall_d;
    end
  end

  // Frames are ignored while neither enable is set
  chk_enable_gate: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
      clk_en && rx_pause_valid && !manual_pause_enable_q && !pause_autoneg_agreed_q
      && !pause_timing_active && !manual_load |=> !pause_timing_active)
    else $error("pause frame accepted while reception disabled");

  // Clearing the manual enable ends the interval at once
  chk_terminate_now: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
      clk_en && terminate && pause_timing_active
      |=> !tx_pause_hold && pause_counter_value_q == 16'h0000 && !pause_frame_seen_q)
    else $error("pause not terminated by enable clear");

  // Reserved multicast frame loads its length
  chk_mcast_load: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
      clk_en && rx_pause_valid && rx_enable && pause_on_reserved_multicast_q
      && rx_dest_addr == `PFC_RESERVED_MCAST && !terminate
      |=> pause_counter_value_q == $past(rx_pause_length))
    else $error("reserved multicast pause frame not taken");

  // Station match frame loads its length
  chk_station_load: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
      clk_en && rx_pause_valid && rx_enable && pause_on_station_match_q
      && (rx_perfect_hit || rx_pattern_hit) && !terminate
      |=> pause_counter_value_q == $past(rx_pause_length)
          && pause_frame_seen_q == ($past(rx_pause_length) != 16'h0000))
    else $error("station match pause frame not taken");

  // Active tracks a nonzero count, and hold follows active
  chk_active_count: assert property (@(posedge pclk) disable iff (!presetn) // [R7]
      pause_timing_active == (pause_counter_value_q != 16'h0000) && tx_pause_hold == pause_timing_active)
    else $error("active bit disagrees with counter");

  // Received bit never outlives the interval
  chk_seen_active: assert property (@(posedge pclk) disable iff (!presetn) // [R8]
      pause_frame_seen_q |-> pause_timing_active)
    else $error("received bit set without active interval");

  // Negotiated bit needs both agreement and advertisement
  chk_autoneg_pair: assert property (@(posedge pclk) disable iff (!presetn) // [R9]
      clk_en && !(an_pause_agreed && cfg_pause_advertise) |=> !pause_autoneg_agreed_q)
    else $error("negotiated bit set without advertisement");

  // Manual load bit reads zero, count reads live
  chk_read_load: assert property (@(posedge pclk) disable iff (!presetn) // [R11] [R12]
      clk_en && psel && penable && !pready_q && !pwrite && hit_reg
      |=> prdata[`PFC_MANUAL_COUNT_LOAD] == 1'b0
          && prdata[`PFC_COUNT_MSB:0] == $past(pause_counter_value_q))
    else $error("bad read of pause control register");

  // A load during an interval is ignored
  chk_load_blocked: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
      clk_en && wr_commit && pwdata[`PFC_MANUAL_COUNT_LOAD] && pause_timing_active
      && !frame_accept && !terminate && !slot.tick
      |=> pause_counter_value_q == $past(pause_counter_value_q))
    else $error("manual load disturbed running interval");

  // A manual load while idle takes the written count and leaves the received bit clear
  chk_manual_start: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
      clk_en && manual_load && !frame_accept
      |=> pause_counter_value_q == $past(pwdata[`PFC_COUNT_MSB:0]) && !pause_frame_seen_q)
    else $error("manual load did not start an interval");

  // A running interval moves its counter within one slot
  chk_slot_decrement: assert property (@(posedge pclk) disable iff (!presetn) // [R14]
      stall_q <= CHK_SLOT_MAX)
    else $error("pause counter stalled");

endmodule : pfc_top

// file: sim/pfc_link_partner.sv
// Far-side model: a remote link partner whose pause frames reach the block as receive filter reports.
// Assumes the bench calls send_frame from its own process, with pclk running.
`timescale 1ns/1ps
module pfc_link_partner (
  // Clock
  input  wire logic        pclk,
  // Pause frame report
  output logic             rx_pause_valid,
  output logic [47:0]      rx_dest_addr,
  output logic [15:0]      rx_pause_length,
  output logic             rx_perfect_hit,
  output logic             rx_pattern_hit
);
  // Quiet report lines until the first frame
  initial begin
    rx_pause_valid  = 1'b0;
    rx_dest_addr    = 48'h0;
    rx_pause_length = 16'h0;
    rx_perfect_hit  = 1'b0;
    rx_pattern_hit  = 1'b0;
  end

  // One frame report after gap idle cycles; afterwards the lines show the inverse, so a stale address never matches the one just sent
  task automatic send_frame(input int gap, input logic [47:0] da, input logic [15:0] len, input logic perf,
                            input logic pat);
    repeat (gap) @(posedge pclk);
    @(posedge pclk);
    rx_pause_valid  <= 1'b1;
    rx_dest_addr    <= da;
    rx_pause_length <= len;
    rx_perfect_hit  <= perf;
    rx_pattern_hit  <= pat;
    @(posedge pclk);
    rx_pause_valid  <= 1'b0;
    rx_dest_addr    <= ~da;
    rx_pause_length <= ~len;
    rx_perfect_hit  <= ~perf;
    rx_pattern_hit  <= ~pat;
  endtask : send_frame
endmodule : pfc_link_partner

// file: sim/pause_frame_flow_control_tb.sv
// Self-checking bench of the pause flow control block: APB master, link partner model, scenarios.
// Assumes the design files and the link partner model are compiled before it.
`timescale 1ns/1ps
`include "pfc_regs.svh"
module pause_frame_flow_control_tb;
  // Register field values
  localparam logic [31:0] MAN_EN = 32'h80000000;
  localparam logic [31:0] MCAST  = 32'h40000000;
  localparam logic [31:0] STAT   = 32'h20000000;
  localparam logic [31:0] LOAD   = 32'h00010000;
  localparam logic [11:0] REG    = `PFC_PAUSE_FLOW_CONTROL;
  localparam logic [47:0] RMC    = `PFC_RESERVED_MCAST;
  localparam int          SLOT   = `PFC_SLOT_CYC_100M;
  // Bench signals
  logic        pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, v;
  logic        rx_pause_valid, rx_perfect_hit, rx_pattern_hit, tx_pause_hold;
  logic [47:0] rx_dest_addr;
  logic [15:0] rx_pause_length;
  logic        link_speed_100, an_pause_agreed, cfg_pause_advertise;
  int          mismatches, compares;

  // Design and far-side model
  pfc_top i_pfc_top (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .rx_pause_valid(rx_pause_valid), .rx_dest_addr(rx_dest_addr), .rx_pause_length(rx_pause_length),
    .rx_perfect_hit(rx_perfect_hit), .rx_pattern_hit(rx_pattern_hit), .link_speed_100(link_speed_100),
    .an_pause_agreed(an_pause_agreed), .cfg_pause_advertise(cfg_pause_advertise), .tx_pause_hold(tx_pause_hold));
  pfc_link_partner i_pfc_link_partner (.pclk(pclk), .rx_pause_valid(rx_pause_valid), .rx_dest_addr(rx_dest_addr),
    .rx_pause_length(rx_pause_length), .rx_perfect_hit(rx_perfect_hit), .rx_pattern_hit(rx_pattern_hit));

  // Clock, 50 ns period
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // Verdict and end of run
  task automatic finish_test();
    $display("Checks made %0d, mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test

  // One comparison
  task automatic chk(input bit ok, input string msg);
    compares++;
    if (!ok) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask : chk

  // One APB transfer; waits for pready as long as it takes, the watchdog ends a hang
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Control register write and read
  task automatic wr(input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, REG, d, r, e);
  endtask : wr
  task automatic rd(output logic [31:0] r);
    logic e;
    apb(1'b0, REG, 32'h0, r, e);
  endtask : rd

  // Counts cycles until the hold drops and checks the interval and cleared status
  task automatic wait_end(input int exp);
    int n;
    n = 0;
    while (tx_pause_hold === 1'b1 && n < exp + 20) begin
      @(posedge pclk);
      n++;
    end
    chk(n >= exp - 8 && n <= exp + 3, "pause interval length");
    rd(v);
    chk(v[23:22] === 2'b00 && v[15:0] === 16'h0, "status not cleared at end");
  endtask : wait_end

  // Reset values, read-only bits, unmapped address
  task automatic t_reset();
    logic e;
    rd(v);
    chk(v === `PFC_PAUSE_FLOW_RESET, "reset value");
    apb(1'b0, 12'h048, 32'h0, v, e);
    chk(e === 1'b1 && v === 32'h0, "unmapped read");
    wr(32'h00E00000);
    rd(v);
    chk(v === 32'h0, "read-only bits written");
  endtask : t_reset

  // Reserved multicast frames: exact address only
  task automatic t_mcast();
    wr(MAN_EN | MCAST);
    i_pfc_link_partner.send_frame(0, RMC ^ 48'h1, 16'h2, 1'b1, 1'b1);
    @(posedge pclk);
    chk(tx_pause_hold === 1'b0, "near-miss address accepted");
    i_pfc_link_partner.send_frame(3, RMC, 16'h2, 1'b0, 1'b0);
    @(posedge pclk);
    chk(tx_pause_hold === 1'b1, "reserved multicast refused");
    wait_end(2 * SLOT);
  endtask : t_mcast

  // Station match frames, reload, refused manual load, length zero
  task automatic t_station();
    wr(MAN_EN | STAT);
    i_pfc_link_partner.send_frame(0, RMC, 16'h7, 1'b0, 1'b0);
    @(posedge pclk);
    chk(tx_pause_hold === 1'b0, "frame without match accepted");
    i_pfc_link_partner.send_frame(0, 48'h0, 16'h7, 1'b1, 1'b0);
    rd(v);
    chk(v[23:22] === 2'b11 && v[15:0] === 16'h7, "perfect hit frame");
    i_pfc_link_partner.send_frame(0, 48'h0, 16'h9, 1'b0, 1'b1);
    rd(v);
    chk(v[15:0] === 16'h9, "reload by pattern hit frame");
    wr(MAN_EN | STAT | LOAD | 32'h0100);
    rd(v);
    chk(v[23:22] === 2'b11 && v[15:0] === 16'h9, "manual load disturbed interval");
    i_pfc_link_partner.send_frame(0, 48'h0, 16'h0, 1'b1, 1'b0);
    @(posedge pclk);
    chk(tx_pause_hold === 1'b0, "length zero did not end pause");
  endtask : t_station

  // Enable by autonegotiation only when advertised
  task automatic t_autoneg();
    wr(STAT);
    i_pfc_link_partner.send_frame(0, 48'h0, 16'h4, 1'b1, 1'b0);
    @(posedge pclk);
    chk(tx_pause_hold === 1'b0, "accepted while disabled");
    an_pause_agreed <= 1'b1;
    rd(v);
    chk(v[21] === 1'b0, "negotiated without advertise");
    cfg_pause_advertise <= 1'b1;
    rd(v);
    chk(v[21] === 1'b1, "negotiated bit missing");
    i_pfc_link_partner.send_frame(0, 48'h0, 16'h4, 1'b1, 1'b0);
    @(posedge pclk);
    chk(tx_pause_hold === 1'b1, "negotiated enable ignored");
    i_pfc_link_partner.send_frame(0, 48'h0, 16'h0, 1'b1, 1'b0);
    an_pause_agreed     <= 1'b0;
    cfg_pause_advertise <= 1'b0;
  endtask : t_autoneg

  // Manual load at 10 Mb/s: one slot of 1024 cycles
  task automatic t_manual();
    link_speed_100 <= 1'b0;
    wr(LOAD | 32'h0001);
    rd(v);
    chk(v[23:22] === 2'b10 && v[16] === 1'b0 && v[15:0] === 16'h1, "manual load");
    wait_end(`PFC_SLOT_CYC_10M - 4);
    link_speed_100 <= 1'b1;
  endtask : t_manual

  // A low clock enable freezes a running pause; clearing the manual enable ends it
  task automatic t_terminate();
    wr(MAN_EN | MCAST);
    i_pfc_link_partner.send_frame(0, RMC, 16'h32, 1'b0, 1'b0);
    clk_en <= 1'b0;
    repeat (3 * SLOT) @(posedge pclk);
    clk_en <= 1'b1;
    rd(v);
    chk(v[23:22] === 2'b11 && v[15:0] === 16'h32 && tx_pause_hold === 1'b1, "pause moved while frozen");
    wr(MCAST);
    rd(v);
    chk(v[23:22] === 2'b00 && v[15:0] === 16'h0 && tx_pause_hold === 1'b0, "pause not terminated");
  endtask : t_terminate

  // Main sequence
  initial begin
    mismatches = 0;
    compares = 0;
    presetn = 1'b0;
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    link_speed_100 = 1'b1;
    an_pause_agreed = 1'b0;
    cfg_pause_advertise = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_mcast();
    t_station();
    t_autoneg();
    t_manual();
    t_terminate();
    finish_test();
  end

  // Watchdog, well beyond the expected run of some 1700 cycles
  initial begin
    repeat (10000) @(posedge pclk);
    mismatches++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    finish_test();
  end
endmodule : pause_frame_flow_control_tb
